// *** bench/svre_engine_chk.sv ***
`timescale 1ns/1ns
module svre_engine_chk #(
	parameter bit IN_ORDER = 1'b0
) (
	input wire logic                  mclk,           // Clock
	input wire logic                  resetn,         // Reset
	input wire logic                  enable,         // Queue on
	input wire svre_pkg::svre_cfg_s   cfg,            // Setup
	input wire logic                  used_notify,    // Used pulse
	input wire logic                  offer_in_order, // In-order
	input wire svre_pkg::svre_mreq_s  mreq,           // Request
	input wire logic                  mreq_valid,     // Req valid
	input wire logic                  mreq_ready,     // Req taken
	input wire svre_pkg::svre_chain_s chain,          // Descriptor
	input wire logic                  chain_valid,    // Desc valid
	input wire logic                  chain_ready,    // Desc taken
	input wire logic                  comp_ready,     // Comp taken
	input wire svre_pkg::svre_err_s   err,            // Errors
	input wire logic [15:0]           used_idx,       // Used index
	input wire logic [16:0]           in_flight       // Outstanding
);
	// ****************
	// Checks
	// ****************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire logic        wr_acc = mreq_valid && mreq_ready && mreq.we;
	wire logic        idx_wr = wr_acc && mreq.size == svre_pkg::SZ2;
	wire logic [63:0] u_end  = cfg.used_base + 64'h6 + {45'h0, cfg.queue_size, 3'h0};
	wire logic [15:0] qs_m1  = cfg.queue_size - 16'h1;

	chk_notify_pulse: assert property (used_notify |=> !used_notify)
		else $error("notify too long");
	chk_notify_after: assert property (used_notify |-> $past(idx_wr) || $past(idx_wr, 2))
		else $error("notify before index write");
	chk_used_only: assert property (wr_acc && !cfg.legacy |-> mreq.addr >= cfg.used_base
		&& mreq.addr + 64'(mreq.size) <= u_end) else $error("write outside used ring");
	chk_write_align: assert property (wr_acc |-> (mreq.addr[3:0] & (mreq.size - 4'h1)) == 4'h0)
		else $error("misaligned write");
	chk_req_hold: assert property (mreq_valid && !mreq_ready && enable |=> mreq_valid && $stable(mreq))
		else $error("request dropped");
	chk_chain_hold: assert property (chain_valid && !chain_ready && enable |=> $stable(chain))
		else $error("descriptor changed");
	chk_flight_cap: assert property (enable && !err.cfg_bad |-> in_flight <= {1'b0, cfg.queue_size})
		else $error("too many outstanding");
	chk_comp_gate: assert property (comp_ready |-> enable && in_flight != 17'h0)
		else $error("completion taken when idle");
	chk_idx_step: assert property (enable && $past(enable) && used_idx != $past(used_idx)
		|-> used_idx == $past(used_idx) + 16'h1) else $error("used index jump");
	chk_disable_clr: assert property (!enable |=> used_idx == 16'h0 && in_flight == 17'h0)
		else $error("disable left state");
	chk_in_order: assert property (offer_in_order == IN_ORDER)
		else $error("in-order offer wrong");
	chk_qs_pow2: assert property (enable && (cfg.queue_size & qs_m1) != 16'h0 |-> ##[0:4] err.cfg_bad)
		else $error("bad size accepted");
endmodule

// *** bench/svre_engine_test.sv ***
`timescale 1ns/1ns
module svre_engine_test;
	localparam logic [15:0] FL [4] = '{16'h1, 16'h2, 16'h3, 16'h2};
	localparam logic [15:0] NX [4] = '{16'h1, 16'h0, 16'h3, 16'h0};
	logic                  mclk, resetn, enable, avail_notify, slow, be;
	logic                  chain_ready, comp_valid, mreq_ready, mrsp_valid, used_notify;
	logic                  offer_in_order, mreq_valid, chain_valid, comp_ready;
	logic [15:0]           comp_head, used_idx, qs, aidx, uidx;
	logic [31:0]           comp_len;
	logic [63:0]           mrsp_data, db, ab, ub;
	logic [16:0]           in_flight;
	svre_pkg::svre_cfg_s   cfg;
	svre_pkg::svre_mreq_s  mreq;
	svre_pkg::svre_chain_s chain;
	svre_pkg::svre_err_s   err;
	svre_pkg::svre_chain_s got [$];
	int                    error_cnt, tests_run, cyc;

	svre_engine #(.QMAX(16), .CHAIN_MAX(3)) dut (.mclk(mclk), .resetn(resetn), .enable(enable),
		.cfg(cfg), .avail_notify(avail_notify), .used_notify(used_notify),
		.offer_in_order(offer_in_order), .mreq(mreq), .mreq_valid(mreq_valid),
		.mreq_ready(mreq_ready), .mrsp_valid(mrsp_valid), .mrsp_data(mrsp_data),
		.chain(chain), .chain_valid(chain_valid), .chain_ready(chain_ready),
		.comp_valid(comp_valid), .comp_head(comp_head), .comp_len(comp_len),
		.comp_ready(comp_ready), .err(err), .used_idx(used_idx), .in_flight(in_flight));
	svre_host_mem u_host (.mclk(mclk), .resetn(resetn), .slow(slow), .mreq(mreq),
		.mreq_valid(mreq_valid), .mreq_ready(mreq_ready), .mrsp_valid(mrsp_valid),
		.mrsp_data(mrsp_data));

	// ****************
	// Helpers
	// ****************
	always #5 mclk = ~mclk;
	always @(posedge mclk) begin
		chain_ready <= 1'($urandom_range(0, 1));
		slow        <= ($urandom_range(0, 3) == 0);
		cyc         <= cyc + 1;
		if (chain_valid && chain_ready)
			got.push_back(chain);
		if (cyc == 40000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [63:0] a, input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
			u_host.mem[a + i] = be ? v[8*(n-1-i)+:8] : v[8*i+:8];
	endtask
	function automatic logic [63:0] rd(input logic [63:0] a, input int n);
		rd = 64'h0;
		for (int i = 0; i < n; i++)
			rd[8*(be ? n-1-i : i)+:8] = u_host.mem[a + i];
	endfunction
	task automatic desc(input int i, input logic [31:0] len, input logic [15:0] fl, nx);
		wr(db + 64'h10 * i, 64'h10000 + 64'h1000 * i, 8);
		wr(db + 64'h10 * i + 64'h8, 64'(len), 4);
		wr(db + 64'h10 * i + 64'hC, 64'(fl), 2);
		wr(db + 64'h10 * i + 64'hE, 64'(nx), 2);
	endtask
	task automatic setup(input logic leg, big, input logic [15:0] q, input logic [63:0] d, a, u);
		@(posedge mclk);
		enable <= 1'b0;
		repeat (3) @(posedge mclk);
		qs = q;
		be = big;
		db = d;
		aidx = 16'h0;
		uidx = 16'h0;
		got.delete();
		ab = leg ? d + 64'h10 * q : a;
		ub = leg ? (ab + 64'h6 + 64'h2 * q + 64'hFFF) & ~64'hFFF : u;
		cfg <= '{q, d, a, u, leg, big};
		wr(ab + 64'h2, 64'h0, 2);
		@(posedge mclk);
		enable <= 1'b1;
	endtask
	task automatic comp(input logic [15:0] h, input logic [31:0] cl, input logic [31:0] ws);
		logic [31:0] ln;
		ln = (cl < ws) ? cl : ws;
		@(posedge mclk);
		comp_valid <= 1'b1;
		comp_head <= h;
		comp_len <= cl;
		@(negedge mclk);
		for (int k = 0; k < 100 && comp_ready !== 1'b1; k++)
			@(negedge mclk);
		@(posedge mclk);
		comp_valid <= 1'b0;
		for (int k = 0; k < 100 && used_notify !== 1'b1; k++)
			@(negedge mclk);
		chk(used_notify, 1'b1);
		chk(rd(ub + 64'h4 + 64'h8 * (uidx % qs), 4), h);
		chk(rd(ub + 64'h8 + 64'h8 * (uidx % qs), 4), ln);
		uidx++;
		chk(rd(ub + 64'h2, 2), uidx);
		chk(used_idx, uidx);
	endtask
	task automatic round(input bit ntf);
		logic [31:0]           ln [4];
		svre_pkg::svre_chain_s c;
		for (int i = 0; i < 4; i++) begin
			ln[i] = 32'($urandom_range(1, 300));
			desc(i, ln[i], FL[i], NX[i]);
		end
		wr(ab + 64'h4 + 64'h2 * (aidx % qs), 64'h0, 2);
		wr(ab + 64'h4 + 64'h2 * ((aidx + 16'h1) % qs), 64'h2, 2);
		aidx += 16'h2;
		wr(ab + 64'h2, 64'(aidx), 2);
		@(posedge mclk);
		avail_notify <= ntf;
		@(posedge mclk);
		avail_notify <= 1'b0;
		for (int k = 0; k < 400 && got.size() < 4; k++)
			@(negedge mclk);
		repeat (2) @(negedge mclk);
		chk(in_flight, 17'h2);
		chk(err, 4'h0);
		for (int i = 0; i < 4; i++) begin
			c = got.pop_front();
			chk(c.head, (i < 2) ? 16'h0 : 16'h2);
			chk(c.last, i % 2);
			chk(c.desc.len, ln[i]);
			chk(c.desc.addr, 64'h10000 + 64'h1000 * i);
			chk({c.desc.flags, c.desc.next}, {FL[i], NX[i]});
		end
		comp(16'h2, 32'($urandom_range(0, 700)), ln[2] + ln[3]);
		comp(16'h0, 32'($urandom_range(0, 400)), ln[1]);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************
	// Sequence
	// ****************
	initial begin
		void'($urandom(32'h8146877B));
		mclk = 1'b0;
		resetn = 1'b0;
		enable = 1'b0;
		avail_notify = 1'b0;
		slow = 1'b0;
		chain_ready = 1'b0;
		comp_valid = 1'b0;
		comp_head = 16'h0;
		comp_len = 32'h0;
		cfg = '0;
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		@(negedge mclk);
		chk(used_idx, 16'h0);
		chk(err, 4'h0);
		setup(1'b0, 1'b0, 16'h4, 64'h1000, 64'h2000, 64'h3000);
		for (int r = 0; r < 3; r++)
			round(r[0]);
		setup(1'b1, 1'b1, 16'h4, 64'h4000, 64'h0, 64'h0);
		round(1'b1);
		setup(1'b1, 1'b0, 16'h8, 64'h8000, 64'h0, 64'h0);
		round(1'b0);
		for (int e = 0; e < 3; e++) begin
			setup(1'b0, 1'b0, 16'h4, 64'h1000, 64'h2000, 64'h3000);
			desc(0, 32'h10, (e == 0) ? 16'h4 : (e == 1) ? 16'h3 : 16'h1, 16'h1);
			desc(1, 32'h10, (e == 1) ? 16'h0 : 16'h1, 16'h2);
			desc(2, 32'h10, 16'h1, 16'h3);
			desc(3, 32'h10, 16'h0, 16'h0);
			wr(ab + 64'h4, 64'h0, 2);
			wr(ab + 64'h2, 64'h1, 2);
			for (int k = 0; k < 300 && err === 4'h0; k++)
				@(negedge mclk);
			chk(err, (e == 0) ? 4'h1 : (e == 1) ? 4'h2 : 4'h4);
		end
		for (int e = 0; e < 5; e++) begin
			setup(1'b0, 1'b0, (e == 0) ? 16'h6 : (e == 1) ? 16'h20 : 16'h4,
				(e == 2) ? 64'h1008 : 64'h1000, (e == 4) ? 64'h2001 : 64'h2000,
				(e == 3) ? 64'h3002 : 64'h3000);
			repeat (4) @(negedge mclk);
			chk(err.cfg_bad, 1'b1);
		end
		wrap_up();
	end
endmodule

bind svre_engine svre_engine_chk #(.IN_ORDER(IN_ORDER)) u_chk (.mclk(mclk), .resetn(resetn),
	.enable(enable), .cfg(cfg), .used_notify(used_notify), .offer_in_order(offer_in_order),
	.mreq(mreq), .mreq_valid(mreq_valid), .mreq_ready(mreq_ready), .chain(chain),
	.chain_valid(chain_valid), .chain_ready(chain_ready), .comp_ready(comp_ready),
	.err(err), .used_idx(used_idx), .in_flight(in_flight));

// *** bench/svre_host_mem.sv ***
`timescale 1ns/1ns
module svre_host_mem (
	input  wire logic                 mclk,       // Clock
	input  wire logic                 resetn,     // Reset
	input  wire logic                 slow,       // Stall now
	input  wire svre_pkg::svre_mreq_s mreq,       // Request
	input  wire logic                 mreq_valid, // Req valid
	output logic                      mreq_ready, // Req taken
	output logic                      mrsp_valid, // Data valid
	output logic [63:0]               mrsp_data   // Read data
);
	// ****************
	// Host memory
	// ****************
	logic [7:0]  mem [logic [63:0]];
	logic        pend;
	logic [63:0] rd_q;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mreq_ready <= 1'b0;
			mrsp_valid <= 1'b0;
			mrsp_data  <= 64'h0;
			pend       <= 1'b0;
		end else begin
			mreq_ready <= !slow;
			mrsp_valid <= 1'b0;
			mrsp_data  <= ~mrsp_data;  // No stale data between answers
			if (pend && !slow) begin
				mrsp_valid <= 1'b1;
				mrsp_data  <= rd_q;
				pend       <= 1'b0;
			end
			if (mreq_valid && mreq_ready) begin
				for (int i = 0; i < 8; i++) begin
					if (mreq.we && i < mreq.size)
						mem[mreq.addr + i] = mreq.wdata[8*i+:8];
					rd_q[8*i+:8] = mem.exists(mreq.addr + i) ? mem[mreq.addr + i] : 8'h0;
				end
				pend <= !mreq.we;
			end
		end
	end
endmodule

// *** hw/svre_cap_mem.sv ***
`timescale 1ns/1ns
module svre_cap_mem #(
	parameter int DEPTH = 256,
	parameter int WIDTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             mclk,    // Clock
	input  wire logic             we,      // Write strobe
	input  wire logic [AW-1:0]    waddr,   // Write index
	input  wire logic [WIDTH-1:0] wdata,   // Write data
	input  wire logic [AW-1:0]    raddr,   // Read index
	output logic      [WIDTH-1:0] rdata    // Registered read data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule

// *** hw/svre_engine.sv ***
`timescale 1ns/1ns
module svre_engine #(
	parameter int QMAX      = 256,
	parameter int CHAIN_MAX = 64,
	parameter bit IN_ORDER  = 1'b0,
	parameter int QAW       = $clog2(QMAX)
) (
	input  wire logic                  mclk,          // Clock, 100 MHz
	input  wire logic                  resetn,        // Async reset, active low
	input  wire logic                  enable,        // Queue enabled; low resets indices
	input  wire svre_pkg::svre_cfg_s   cfg,           // Queue configuration
	input  wire logic                  avail_notify,  // Available-buffer notification pulse
	output logic                       used_notify,   // Used-buffer notification pulse
	output logic                       offer_in_order,// In-order feature offered
	output svre_pkg::svre_mreq_s       mreq,          // Memory request
	output logic                       mreq_valid,    // Memory request valid
	input  wire logic                  mreq_ready,    // Memory request accepted
	input  wire logic                  mrsp_valid,    // Read response valid
	input  wire logic [63:0]           mrsp_data,     // Read data, lowest address in low byte
	output svre_pkg::svre_chain_s      chain,         // Descriptor to device core
	output logic                       chain_valid,   // Descriptor valid
	input  wire logic                  chain_ready,   // Descriptor taken
	input  wire logic                  comp_valid,    // Completion from core
	input  wire logic [15:0]           comp_head,     // Completed chain head
	input  wire logic [31:0]           comp_len,      // Bytes written by core
	output logic                       comp_ready,    // Completion taken
	output svre_pkg::svre_err_s        err,           // Sticky error flags
	output logic [15:0]                used_idx,      // Device used index
	output logic [16:0]                in_flight      // Buffers outstanding
);

	// ************************************************************
	// States
	// ************************************************************
	typedef enum logic [3:0] {
		S_IDLE, S_POLL, S_POLL_W, S_HEAD, S_HEAD_W, S_D0, S_D0_W, S_D1, S_D1_W,
		S_EMIT, S_CAP, S_USED_ID, S_USED_LEN, S_USED_IDX, S_HALT
	} svre_state_e;

	svre_state_e          state_q, state_d;
	logic [15:0]          last_avail_q, avail_idx_q, used_idx_q, head_q, cur_q;
	logic [16:0]          in_flight_q;
	logic [15:0]          chain_cnt_q;
	logic                 seen_wr_q;
	logic [31:0]          cap_q, comp_len_q;
	logic [15:0]          comp_head_q;
	logic [63:0]          lo_q;
	svre_pkg::svre_desc_s desc_q;
	svre_pkg::svre_err_s  err_q;
	logic                 notify_pend_q, used_notify_q;
	logic [7:0]           poll_q;

	// ************************************************************
	// Byte order
	// ************************************************************
	function automatic logic [63:0] fix(input logic [63:0] v, input logic [3:0] n,
		input logic be);
		logic [63:0] r;
		r = v;
		if (be) begin
			r = 64'h0;
			for (int i = 0; i < 8; i++) begin
				if (i < int'(n)) begin
					r[8*i +: 8] = v[8*(int'(n)-1-i) +: 8];
				end
			end
		end
		return r;
	endfunction

	wire swap = cfg.legacy & cfg.guest_be;

	// ************************************************************
	// Geometry and configuration checks
	// ************************************************************
	wire [15:0] qs      = cfg.queue_size;
	wire [15:0] qmask   = qs - 16'h0001;
	wire        qs_pow2 = (qs != 16'h0000) && ((qs & qmask) == 16'h0000);
	wire        qs_fits = ({1'b0, qs} <= svre_pkg::QSZ_MAX) && (32'(qs) <= 32'(QMAX));

	// Legacy places the rings back to back with the used ring page aligned
	wire [63:0] desc_b    = cfg.desc_base;
	wire [63:0] avail_leg = desc_b + 64'(32'(svre_pkg::DESC_BYTES) * 32'(qs));
	wire [63:0] avail_b   = cfg.legacy ? avail_leg : cfg.avail_base;
	wire [63:0] avail_end = avail_b + 64'(svre_pkg::AVAIL_HDR)
		+ 64'(32'(svre_pkg::AVAIL_ENTRY) * 32'(qs));
	wire [63:0] qal_m     = 64'(svre_pkg::QALIGN) - 64'h1;
	wire [63:0] used_leg  = (avail_end + qal_m) & ~qal_m;
	wire [63:0] used_b    = cfg.legacy ? used_leg : cfg.used_base;

	// Misplaced parts are refused rather than silently used
	wire align_ok = ((desc_b & svre_pkg::DESC_ALIGN_M) == 64'h0)
		&& ((avail_b & svre_pkg::AVAIL_ALIGN_M) == 64'h0)
		&& ((used_b & svre_pkg::USED_ALIGN_M) == 64'h0);
	wire cfg_ok = qs_pow2 && qs_fits && align_ok;

	// ************************************************************
	// Addresses of ring fields
	// ************************************************************
	wire [15:0] avail_slot = last_avail_q & qmask;
	wire [15:0] used_slot  = used_idx_q & qmask;
	wire [15:0] desc_slot  = cur_q & qmask;
	wire [63:0] a_avail_ix = avail_b + svre_pkg::RING_IDX_OFS;
	wire [63:0] a_head     = avail_b + svre_pkg::RING_ENT_OFS
		+ 64'(32'(svre_pkg::AVAIL_ENTRY) * 32'(avail_slot));
	wire [63:0] a_desc     = desc_b + 64'(32'(svre_pkg::DESC_BYTES) * 32'(desc_slot));
	wire [63:0] a_used_el  = used_b + svre_pkg::RING_ENT_OFS
		+ 64'(32'(svre_pkg::USED_ENTRY) * 32'(used_slot));
	wire [63:0] a_used_ix  = used_b + svre_pkg::RING_IDX_OFS;

	// ************************************************************
	// Decoded read data
	// ************************************************************
	wire [15:0] rsp_u16   = 16'(fix(mrsp_data, svre_pkg::SZ2, swap));
	wire [63:0] rsp_u64   = fix(mrsp_data, svre_pkg::SZ8, swap);
	wire [31:0] rsp_len   = 32'(fix({32'h0, mrsp_data[31:0]}, svre_pkg::SZ4, swap));
	wire [15:0] rsp_flags = 16'(fix({48'h0, mrsp_data[47:32]}, svre_pkg::SZ2, swap));
	wire [15:0] rsp_next  = 16'(fix({48'h0, mrsp_data[63:48]}, svre_pkg::SZ2, swap));

	wire rsp_wr    = rsp_flags[svre_pkg::FLAG_WRITE];
	wire bad_ind   = rsp_flags[svre_pkg::FLAG_INDIRECT];
	wire bad_order = seen_wr_q && !rsp_wr;
	wire bad_long  = rsp_flags[svre_pkg::FLAG_NEXT]
		&& (32'(chain_cnt_q) + 32'h1 >= 32'(CHAIN_MAX));

	// ************************************************************
	// Capacity memory: writable bytes per outstanding head
	// ************************************************************
	wire [31:0] cap_rd;
	wire        cap_we = (state_q == S_EMIT) && chain_ready
		&& !desc_q.flags[svre_pkg::FLAG_NEXT];
	wire [31:0] cap_fin = desc_q.flags[svre_pkg::FLAG_WRITE] ? cap_q + desc_q.len : cap_q;

	svre_cap_mem #(
		.DEPTH (QMAX),
		.WIDTH (32)
	) u_cap (
		.mclk  (mclk),
		.we    (cap_we),
		.waddr (head_q[QAW-1:0]),
		.wdata (cap_fin),
		.raddr (comp_head[QAW-1:0]),
		.rdata (cap_rd)
	);

	// ************************************************************
	// Control decisions
	// ************************************************************
	wire can_fetch = (last_avail_q != avail_idx_q) && (in_flight_q < {1'b0, qs});
	wire do_poll   = notify_pend_q || (32'(poll_q) >= 32'(svre_pkg::POLL_CYC));
	// Never take a completion that the idle branch would drop
	wire take_comp = (state_q == S_IDLE) && enable && cfg_ok && comp_valid
		&& (in_flight_q != 17'h0);

	// Completions in any order are accepted
	assign comp_ready     = take_comp;
	assign offer_in_order = IN_ORDER;

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (!enable) begin
					state_d = S_IDLE;
				end else if (!cfg_ok) begin
					state_d = S_HALT;
				end else if (take_comp) begin
					state_d = S_CAP;
				end else if (can_fetch) begin
					state_d = S_HEAD;
				end else if (do_poll) begin
					state_d = S_POLL;
				end
			end
			S_POLL:     if (mreq_ready) state_d = S_POLL_W;
			S_POLL_W:   if (mrsp_valid) state_d = S_IDLE;
			S_HEAD:     if (mreq_ready) state_d = S_HEAD_W;
			S_HEAD_W:   if (mrsp_valid) state_d = S_D0;
			S_D0:       if (mreq_ready) state_d = S_D0_W;
			S_D0_W:     if (mrsp_valid) state_d = S_D1;
			S_D1:       if (mreq_ready) state_d = S_D1_W;
			S_D1_W: begin
				if (mrsp_valid) begin
					state_d = (bad_ind || bad_order || bad_long) ? S_HALT : S_EMIT;
				end
			end
			S_EMIT: begin
				if (chain_ready) begin
					state_d = desc_q.flags[svre_pkg::FLAG_NEXT] ? S_D0 : S_IDLE;
				end
			end
			S_CAP:      state_d = S_USED_ID;
			S_USED_ID:  if (mreq_ready) state_d = S_USED_LEN;
			S_USED_LEN: if (mreq_ready) state_d = S_USED_IDX;
			S_USED_IDX: if (mreq_ready) state_d = S_IDLE;
			S_HALT:     if (!enable) state_d = S_IDLE;
			default:    state_d = S_IDLE;
		endcase
	end

	// ************************************************************
	// Memory requests: reads of driver parts, writes to used ring only
	// ************************************************************
	wire wr_state = (state_q == S_USED_ID) || (state_q == S_USED_LEN)
		|| (state_q == S_USED_IDX);
	wire [15:0] used_next = used_idx_q + 16'h0001;

	assign mreq_valid = (state_q == S_POLL) || (state_q == S_HEAD) || (state_q == S_D0)
		|| (state_q == S_D1) || wr_state;
	assign mreq.we    = wr_state;
	assign mreq.addr  = (state_q == S_POLL)     ? a_avail_ix :
	                    (state_q == S_HEAD)     ? a_head :
	                    (state_q == S_D0)       ? a_desc :
	                    (state_q == S_D1)       ? a_desc + svre_pkg::DESC_HI_OFS :
	                    (state_q == S_USED_ID)  ? a_used_el :
	                    (state_q == S_USED_LEN) ? a_used_el + svre_pkg::USED_LEN_OFS :
	                    a_used_ix;
	assign mreq.size  = ((state_q == S_POLL) || (state_q == S_HEAD)
		|| (state_q == S_USED_IDX)) ? svre_pkg::SZ2 :
	                    ((state_q == S_D0) || (state_q == S_D1)) ? svre_pkg::SZ8 :
	                    svre_pkg::SZ4;
	assign mreq.wdata = (state_q == S_USED_ID)  ? fix({48'h0, comp_head_q}, svre_pkg::SZ4, swap) :
	                    (state_q == S_USED_LEN) ? fix({32'h0, comp_len_q}, svre_pkg::SZ4, swap) :
	                    (state_q == S_USED_IDX) ? fix({48'h0, used_next}, svre_pkg::SZ2, swap) :
	                    64'h0;

	// ************************************************************
	// Outputs
	// ************************************************************
	assign chain_valid = (state_q == S_EMIT);
	assign chain.head  = head_q;
	assign chain.desc  = desc_q;
	assign chain.last  = !desc_q.flags[svre_pkg::FLAG_NEXT];
	assign used_notify = used_notify_q;
	assign used_idx    = used_idx_q;
	assign in_flight   = in_flight_q;
	assign err         = err_q;

	// ************************************************************
	// State registers
	// ************************************************************
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_q <= S_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Indices restart from zero whenever the queue is disabled
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			last_avail_q <= svre_pkg::IDX_RST;
			avail_idx_q  <= svre_pkg::IDX_RST;
			used_idx_q   <= svre_pkg::IDX_RST;
			in_flight_q  <= 17'h00000;
		end else if (!enable) begin
			last_avail_q <= svre_pkg::IDX_RST;
			avail_idx_q  <= svre_pkg::IDX_RST;
			used_idx_q   <= svre_pkg::IDX_RST;
			in_flight_q  <= 17'h00000;
		end else begin
			if (state_q == S_POLL_W && mrsp_valid) begin
				avail_idx_q <= rsp_u16;
			end
			if (cap_we) begin
				last_avail_q <= last_avail_q + 16'h0001;
			end
			if (state_q == S_USED_IDX && mreq_ready) begin
				used_idx_q <= used_next;
			end
			if (cap_we && !(state_q == S_USED_IDX && mreq_ready)) begin
				in_flight_q <= in_flight_q + 17'h00001;
			end else if (state_q == S_USED_IDX && mreq_ready) begin
				in_flight_q <= in_flight_q - 17'h00001;
			end
		end
	end

	// Chain walk
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			head_q      <= 16'h0000;
			cur_q       <= 16'h0000;
			chain_cnt_q <= 16'h0000;
			seen_wr_q   <= 1'b0;
			cap_q       <= 32'h00000000;
			lo_q        <= 64'h0;
			desc_q      <= '0;
		end else begin
			if (state_q == S_HEAD_W && mrsp_valid) begin
				head_q      <= rsp_u16 & qmask;
				cur_q       <= rsp_u16 & qmask;
				chain_cnt_q <= 16'h0000;
				seen_wr_q   <= 1'b0;
				cap_q       <= 32'h00000000;
			end
			if (state_q == S_D0_W && mrsp_valid) begin
				lo_q <= rsp_u64;
			end
			if (state_q == S_D1_W && mrsp_valid) begin
				desc_q <= '{addr: lo_q, len: rsp_len, flags: rsp_flags, next: rsp_next};
			end
			if (state_q == S_EMIT && chain_ready) begin
				cap_q       <= cap_fin;
				cur_q       <= desc_q.next & qmask;
				chain_cnt_q <= chain_cnt_q + 16'h0001;
				seen_wr_q   <= seen_wr_q | desc_q.flags[svre_pkg::FLAG_WRITE];
			end
		end
	end

	// Completion: length clipped to the writable bytes of the chain
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			comp_head_q <= 16'h0000;
			comp_len_q  <= 32'h00000000;
		end else if (take_comp) begin
			comp_head_q <= comp_head;
			comp_len_q  <= comp_len;
		end else if (state_q == S_CAP) begin
			comp_len_q <= (comp_len_q > cap_rd) ? cap_rd : comp_len_q;
		end
	end

	// Notification only once the used index has gone out; set wins over clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			used_notify_q <= 1'b0;
			notify_pend_q <= 1'b0;
			poll_q        <= 8'h00;
			err_q         <= '0;
		end else begin
			used_notify_q <= (state_q == S_USED_IDX) && mreq_ready;
			if (avail_notify) begin
				notify_pend_q <= 1'b1;
			end else if (state_q == S_POLL) begin
				notify_pend_q <= 1'b0;
			end
			poll_q <= (state_q == S_POLL) ? 8'h00 :
				(32'(poll_q) < 32'(svre_pkg::POLL_CYC)) ? poll_q + 8'h01 : poll_q;
			if (!enable) begin
				err_q <= '0;
			end else begin
				if (state_q == S_IDLE && !cfg_ok) err_q.cfg_bad <= 1'b1;
				if (state_q == S_D1_W && mrsp_valid) begin
					if (bad_long)  err_q.chain_long   <= 1'b1;
					if (bad_order) err_q.wr_before_rd <= 1'b1;
					if (bad_ind)   err_q.indirect     <= 1'b1;
				end
			end
		end
	end

endmodule

// *** hw/svre_pkg.sv ***
package svre_pkg;

	// ************************************************************
	// Queue geometry
	// ************************************************************
	localparam int          QSZ_W        = 16;
	localparam logic [16:0] QSZ_MAX      = 17'h08000;
	localparam int          DESC_BYTES   = 16;
	localparam int          AVAIL_HDR    = 6;
	localparam int          AVAIL_ENTRY  = 2;
	localparam int          USED_HDR     = 6;
	localparam int          USED_ENTRY   = 8;
	localparam int          QALIGN       = 4096;

	// Minimum alignment of each ring part, as low-bit masks
	localparam logic [63:0] DESC_ALIGN_M  = 64'h000000000000000F;
	localparam logic [63:0] AVAIL_ALIGN_M = 64'h0000000000000001;
	localparam logic [63:0] USED_ALIGN_M  = 64'h0000000000000003;

	// ************************************************************
	// Field offsets inside the ring parts
	// ************************************************************
	localparam logic [63:0] RING_IDX_OFS  = 64'h0000000000000002;
	localparam logic [63:0] RING_ENT_OFS  = 64'h0000000000000004;
	localparam logic [63:0] USED_LEN_OFS  = 64'h0000000000000004;
	localparam logic [63:0] DESC_HI_OFS   = 64'h0000000000000008;

	// Descriptor flag bit positions
	localparam int          FLAG_NEXT     = 0;
	localparam int          FLAG_WRITE    = 1;
	localparam int          FLAG_INDIRECT = 2;

	// Reset values and poll interval
	localparam logic [15:0] IDX_RST       = 16'h0000;
	localparam int          POLL_CYC      = 64;

	// Access sizes in bytes
	localparam logic [3:0]  SZ2           = 4'h2;
	localparam logic [3:0]  SZ4           = 4'h4;
	localparam logic [3:0]  SZ8           = 4'h8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [15:0] queue_size;
		logic [63:0] desc_base;
		logic [63:0] avail_base;
		logic [63:0] used_base;
		logic        legacy;
		logic        guest_be;
	} svre_cfg_s;

	typedef struct packed {
		logic [63:0] addr;
		logic [31:0] len;
		logic [15:0] flags;
		logic [15:0] next;
	} svre_desc_s;

	typedef struct packed {
		logic [15:0] head;
		svre_desc_s  desc;
		logic        last;
	} svre_chain_s;

	typedef struct packed {
		logic [63:0] addr;
		logic        we;
		logic [3:0]  size;
		logic [63:0] wdata;
	} svre_mreq_s;

	typedef struct packed {
		logic cfg_bad;
		logic chain_long;
		logic wr_before_rd;
		logic indirect;
	} svre_err_s;

endpackage
